/* File: rtl/current_dac_pkg.sv */
// Constants, register map and types of the current converter control.
package current_dac_pkg;

  localparam int unsigned CLOCK_HZ        = 200_000_000;
  localparam int unsigned DATA_WIDTH      = 32;
  localparam int unsigned ADDR_WIDTH      = 32;
  localparam int unsigned WORD_WIDTH      = 10;

  // Register indices; each register takes the word at four times its index.
  localparam logic [11:0] CONTROL_INDEX   = 12'h0B9;
  localparam logic [11:0] DATA_HIGH_INDEX = 12'h097;
  localparam logic [11:0] DATA_LOW_INDEX  = 12'h096;
  localparam logic [11:0] STATUS_INDEX    = 12'h098;
  localparam int unsigned DECODE_WIDTH    = 12;

  // Control register fields.
  localparam int unsigned ENABLE_POS      = 7;
  localparam int unsigned SOURCE_LSB      = 4;
  localparam int unsigned SOURCE_MSB      = 6;
  localparam int unsigned SCALE_LSB       = 0;
  localparam int unsigned SCALE_MSB       = 1;
  localparam logic [7:0]  CONTROL_RESET   = 8'h72;
  localparam logic [7:0]  CONTROL_MASK    = 8'hF3;

  // Data registers.
  localparam logic [7:0]  DATA_HIGH_RESET = 8'h00;
  localparam logic [7:0]  DATA_LOW_RESET  = 8'h00;
  localparam logic [7:0]  DATA_LOW_MASK   = 8'hC0;
  localparam logic [9:0]  WORD_RESET      = 10'h000;

  // Status register fields.
  localparam int unsigned PENDING_POS     = 16;

  // AHB-Lite encodings.
  localparam logic [1:0]  HTRANS_IDLE     = 2'h0;
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
  localparam logic        HRESP_OKAY      = 1'b0;

  typedef enum logic [2:0] {
    SRC_TIMER0    = 3'h0,
    SRC_TIMER1    = 3'h1,
    SRC_TIMER2    = 3'h2,
    SRC_TIMER3    = 3'h3,
    SRC_RISE      = 3'h4,
    SRC_FALL      = 3'h5,
    SRC_ANY_EDGE  = 3'h6,
    SRC_ON_DEMAND = 3'h7
  } update_source_type;

  // Decoded full-scale current handed to the analog core.
  typedef enum logic [1:0] {
    SCALE_HALF_MA = 2'h0,
    SCALE_ONE_MA  = 2'h1,
    SCALE_TWO_MA  = 2'h2
  } full_scale_type;

  localparam full_scale_type SCALE_RESET  = SCALE_TWO_MA;

endpackage

/* File: rtl/current_dac_update_control.sv */
// Register file, update scheduling and pin takeover of the current converter.
`timescale 1ns/10ps
module current_dac_update_control (
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  // AHB-Lite slave.
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic                    hready,
  input  wire logic [31:0]             hwdata,
  output logic [31:0]                  hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  // Update events.
  input  wire logic [3:0]              timer_overflow,
  input  wire logic                    external_conversion_strobe,
  // General-purpose drive requested for the shared pin.
  input  wire logic                    gpio_out,
  input  wire logic                    gpio_oe_n,
  input  wire logic                    gpio_pullup_en,
  // Shared pin and analog core.
  output logic                         pin_out,
  output logic                         pin_oe_n,
  output logic                         pin_pullup_en,
  output logic                         analog_connect,
  output logic                         bias_enable,
  output logic [9:0]                   dac_code,
  output current_dac_pkg::full_scale_type full_scale
);
  import current_dac_pkg::*;

  // Register state.
  logic [7:0]        control_q;
  logic [7:0]        control_d;
  logic [7:0]        data_high_q;
  logic [7:0]        data_high_d;
  logic [7:0]        data_low_q;
  logic [7:0]        data_low_d;
  logic [9:0]        word_q;
  logic              pending_q;

  // Bus pipeline.
  logic              write_phase_q;
  logic [11:0]       write_index_q;
  logic              bus_request;
  logic [11:0]       request_index;

  // Decoded write strobes of the current data phase.
  logic              control_write;
  logic              high_write;
  logic              low_write;

  // Event path.
  logic              strobe_rise;
  logic              strobe_fall;
  logic              load_pulse;
  logic              enable;
  update_source_type source;

  // Word index of a byte address; the two low address bits are ignored.
  function automatic logic [11:0] word_index(input logic [31:0] addr);
    word_index = addr[DECODE_WIDTH+1:2];
  endfunction

  // Full-scale code to current setting.
  function automatic full_scale_type decode_scale(input logic [1:0] code);
    if (code[1]) begin
      decode_scale = SCALE_TWO_MA;
    end else if (code[0]) begin
      decode_scale = SCALE_ONE_MA;
    end else begin
      decode_scale = SCALE_HALF_MA;
    end
  endfunction

  // Read value of a register, built from the next-cycle values of the writable registers.
  function automatic logic [31:0] read_word(
    input logic [11:0] index,
    input logic [7:0]  ctrl,
    input logic [7:0]  high,
    input logic [7:0]  low,
    input logic [9:0]  word,
    input logic        pend
  );
    read_word = 32'h0000_0000;
    unique case (index)
      CONTROL_INDEX:   read_word[7:0] = ctrl & CONTROL_MASK;
      DATA_HIGH_INDEX: read_word[7:0] = high;
      DATA_LOW_INDEX:  read_word[7:0] = low & DATA_LOW_MASK;
      STATUS_INDEX: begin
        read_word[9:0]        = word;
        read_word[PENDING_POS] = pend;
      end
      default:         read_word = 32'h0000_0000;
    endcase
  endfunction

  assign enable = control_q[ENABLE_POS];
  assign source = update_source_type'(control_q[SOURCE_MSB:SOURCE_LSB]);

  // Address phase: a request is taken when selected, active and ready.
  assign bus_request   = hsel & htrans[1] & hready;
  assign request_index = word_index(haddr);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      write_phase_q <= 1'b0;
      write_index_q <= 12'h000;
    end else if (hready) begin
      write_phase_q <= bus_request & hwrite;
      write_index_q <= request_index;
    end
  end

  assign control_write = write_phase_q & (write_index_q == CONTROL_INDEX);
  assign high_write    = write_phase_q & (write_index_q == DATA_HIGH_INDEX);
  assign low_write     = write_phase_q & (write_index_q == DATA_LOW_INDEX);

  // Next values of the software registers.
  always_comb begin
    control_d   = control_q;
    data_high_d = data_high_q;
    data_low_d  = data_low_q;
    if (control_write) begin
      control_d = hwdata[7:0] & CONTROL_MASK;
    end
    if (high_write) begin
      data_high_d = hwdata[7:0];
    end
    if (low_write) begin
      data_low_d = hwdata[7:0] & DATA_LOW_MASK;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      control_q <= CONTROL_RESET;
    end else begin
      control_q <= control_d;
    end
  end

  // Low byte writes only store; they never reach the latch directly.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      data_high_q <= DATA_HIGH_RESET;
      data_low_q  <= DATA_LOW_RESET;
    end else begin
      data_high_q <= data_high_d;
      data_low_q  <= data_low_d;
    end
  end

  strobe_edge_detect i_strobe_edge_detect (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .strobe_in  (external_conversion_strobe),
    .rise_pulse (strobe_rise),
    .fall_pulse (strobe_fall)
  );

  update_trigger_select i_update_trigger_select (
    .ref_clk        (ref_clk),
    .rst            (rst),
    .source         (source),
    .timer_overflow (timer_overflow),
    .strobe_rise    (strobe_rise),
    .strobe_fall    (strobe_fall),
    .high_write     (high_write),
    .load_pulse     (load_pulse)
  );

  // The load pulse follows its event by one cycle, so the held bytes
  // already contain the high byte write that caused an on-demand load.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      word_q <= WORD_RESET;
    end else if (load_pulse) begin
      word_q <= {data_high_q, data_low_q[7:6]};
    end
  end

  // Pending marks held data not yet latched; a new write wins over a load.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pending_q <= 1'b0;
    end else if (high_write | low_write) begin
      pending_q <= 1'b1;
    end else if (load_pulse) begin
      pending_q <= 1'b0;
    end
  end

  // Read data of the writable registers is taken from next-cycle values so a read right after a
  // write returns the written data.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (hready & bus_request & ~hwrite) begin
      hrdata <= read_word(request_index, control_d, data_high_d,
                          data_low_d, word_q, pending_q);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end
  end

  // Analog core controls.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dac_code       <= WORD_RESET;
      full_scale     <= SCALE_RESET;
      bias_enable    <= 1'b0;
      analog_connect <= 1'b0;
    end else begin
      dac_code       <= word_q;
      full_scale     <= decode_scale(control_q[SCALE_MSB:SCALE_LSB]);
      bias_enable    <= enable;
      analog_connect <= enable;
    end
  end

  // Shared pin takeover.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pin_out       <= 1'b0;
      pin_oe_n      <= 1'b1;
      pin_pullup_en <= 1'b0;
    end else if (enable) begin
      pin_out       <= 1'b0;
      pin_oe_n      <= 1'b1;
      pin_pullup_en <= 1'b0;
    end else begin
      pin_out       <= gpio_out;
      pin_oe_n      <= gpio_oe_n;
      pin_pullup_en <= gpio_pullup_en;
    end
  end

endmodule

/* File: rtl/strobe_edge_detect.sv */
// Synchroniser and edge detector for the external conversion strobe.
`timescale 1ns/10ps
module strobe_edge_detect (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic strobe_in,
  output logic      rise_pulse,
  output logic      fall_pulse
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  // Only sync_q reads meta_q.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= strobe_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign rise_pulse = sync_q & ~last_q;
  assign fall_pulse = ~sync_q & last_q;
endmodule

/* File: rtl/update_trigger_select.sv */
// Chooses the event that moves the held data word into the output latch.
`timescale 1ns/10ps
module update_trigger_select (
  input  wire logic                              ref_clk,
  input  wire logic                              rst,
  input  wire current_dac_pkg::update_source_type source,
  input  wire logic [3:0]                        timer_overflow,
  input  wire logic                              strobe_rise,
  input  wire logic                              strobe_fall,
  input  wire logic                              high_write,
  output logic                                   load_pulse
);
  import current_dac_pkg::*;

  logic load_d;

  always_comb begin
    unique case (source)
      SRC_TIMER0:    load_d = timer_overflow[0];
      SRC_TIMER1:    load_d = timer_overflow[1];
      SRC_TIMER2:    load_d = timer_overflow[2];
      SRC_TIMER3:    load_d = timer_overflow[3];
      SRC_RISE:      load_d = strobe_rise;
      SRC_FALL:      load_d = strobe_fall;
      SRC_ANY_EDGE:  load_d = strobe_rise | strobe_fall;
      SRC_ON_DEMAND: load_d = high_write;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      load_pulse <= 1'b0;
    end else begin
      load_pulse <= load_d;
    end
  end
endmodule

/* File: sim/current_dac_monitor.sv */
// Port assertions of the current converter control.
`timescale 1ns/10ps
module current_dac_monitor
  import current_dac_pkg::*;
(
  input wire logic [0:0]  ref_clk,
  input wire logic [0:0]  rst,
  input wire logic [0:0]  hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic [0:0]  hwrite,
  input wire logic [0:0]  hready,
  input wire logic [31:0] hrdata,
  input wire logic [3:0]  timer_overflow,
  input wire logic [0:0]  external_conversion_strobe,
  input wire logic [0:0]  gpio_out,
  input wire logic [0:0]  gpio_oe_n,
  input wire logic [0:0]  gpio_pullup_en,
  input wire logic [0:0]  pin_out,
  input wire logic [0:0]  pin_oe_n,
  input wire logic [0:0]  pin_pullup_en,
  input wire logic [0:0]  analog_connect,
  input wire logic [0:0]  bias_enable,
  input wire logic [9:0]  dac_code,
  input wire current_dac_pkg::full_scale_type full_scale
);
  logic        rd_q;
  logic        wr_q;
  logic        strobe_q;
  logic [11:0] idx_q;
  logic [2:0]  age_q;
  wire logic   ctrl_rd = rd_q && idx_q == CONTROL_INDEX;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      idx_q <= 12'h000;
    end else begin
      rd_q <= hsel && htrans[1] && hready && !hwrite;
      wr_q <= hsel && htrans[1] && hready && hwrite;
      idx_q <= haddr[13:2];
    end
  end

  // Cycles since the last event that may move the output word.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      strobe_q <= 1'b0;
      age_q <= 3'h7;
    end else begin
      strobe_q <= external_conversion_strobe;
      if (wr_q || |timer_overflow || strobe_q != external_conversion_strobe)
        age_q <= 3'h0;
      else if (age_q != 3'h7)
        age_q <= age_q + 3'h1;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  chk_pin_takeover: assert property (
    analog_connect |-> !pin_out && pin_oe_n && !pin_pullup_en)
    else $error("pin still driven while converter enabled");
  chk_gpio_pass: assert property (
    !analog_connect && !$past(rst) |-> pin_out == $past(gpio_out)
    && pin_oe_n == $past(gpio_oe_n) && pin_pullup_en == $past(gpio_pullup_en))
    else $error("pin does not follow its general purpose drive");
  chk_bias_follow: assert property (
    ctrl_rd |=> bias_enable == $past(hrdata[ENABLE_POS]))
    else $error("bias generator not tied to converter enable");
  chk_enable_map: assert property (
    ctrl_rd |=> analog_connect == $past(hrdata[ENABLE_POS]))
    else $error("pin connection differs from enable bit");
  chk_scale_map: assert property (
    ctrl_rd |=> full_scale == ($past(hrdata[1]) ? SCALE_TWO_MA :
    $past(hrdata[0]) ? SCALE_ONE_MA : SCALE_HALF_MA))
    else $error("full scale differs from select field");
  chk_scale_reset: assert property (
    $past(rst) |-> full_scale == SCALE_TWO_MA)
    else $error("full scale after reset is not the highest");
  chk_low_unused: assert property (
    rd_q && idx_q == DATA_LOW_INDEX |-> hrdata[5:0] == 6'h00
    && hrdata[31:8] == 24'h000000)
    else $error("unused low byte bits read nonzero");
  chk_code_cause: assert property (
    $changed(dac_code) |-> age_q != 3'h7)
    else $error("output word moved without an update event");

  cov_ctrl_read: cover property (ctrl_rd && hrdata[ENABLE_POS]);
  cov_code_move: cover property ($changed(dac_code));
  cov_enabled: cover property (analog_connect && bias_enable);
endmodule

bind current_dac_update_control current_dac_monitor i_current_dac_monitor (
  .ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
  .timer_overflow, .external_conversion_strobe, .gpio_out, .gpio_oe_n,
  .gpio_pullup_en, .pin_out, .pin_oe_n, .pin_pullup_en, .analog_connect,
  .bias_enable, .dac_code, .full_scale);

/* File: sim/current_dac_update_control_test.sv */
// Self-checking bench of the current converter control.
`timescale 1ns/10ps
module current_dac_update_control_test;
  import current_dac_pkg::*;
  logic           ref_clk = 1'b0;
  logic           rst = 1'b1;
  logic           hsel = 1'b0;
  logic           hwrite = 1'b0;
  logic           gpio_out = 1'b0;
  logic           gpio_oe_n = 1'b1;
  logic           gpio_pullup_en = 1'b0;
  logic [1:0]     htrans = HTRANS_IDLE;
  logic [31:0]    haddr = 32'h0;
  logic [31:0]    hwdata = 32'h0;
  logic [31:0]    hrdata, rd;
  logic           hreadyout, hresp, strobe, pin_out, pin_oe_n;
  logic           pin_pullup_en, analog_connect, bias_enable;
  logic [3:0]     timer_overflow;
  logic [9:0]     dac_code, code;
  full_scale_type full_scale;
  int             n_errors = 0;
  int             cmp_count = 0;

  always #2.5 ref_clk = ~ref_clk;

  current_dac_update_control i_current_dac_update_control (
    .ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
    .timer_overflow, .external_conversion_strobe(strobe), .gpio_out,
    .gpio_oe_n, .gpio_pullup_en, .pin_out, .pin_oe_n, .pin_pullup_en,
    .analog_connect, .bias_enable, .dac_code, .full_scale);

  event_source_model i_event_source_model (
    .ref_clk, .timer_overflow, .strobe);

  task automatic print_verdict;
    if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      n_errors++;
      print_verdict;
    end
  endtask

  // One single AHB transfer; read data is left in rd.
  task automatic rw(input logic w, input logic [11:0] i, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {18'h0, i, 2'b00};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= HTRANS_IDLE;
    hwdata <= {24'h0, d};
    wait_rdy;
    rd = hrdata;
    check(hresp, HRESP_OKAY, "response");
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rw(0, CONTROL_INDEX, 8'h00);
    check(rd, 32'h72, "control reset");
    check(full_scale, SCALE_TWO_MA, "scale reset");
    rw(0, 12'h000, 8'h00);
    check(rd, 32'h0, "unmapped read");
    gpio_out <= 1'b1;
    gpio_oe_n <= 1'b0;
    gpio_pullup_en <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check({pin_out, pin_oe_n, pin_pullup_en}, 3'b101, "gpio pass");
    for (int s = 0; s < 4; s++) begin
      rw(1, CONTROL_INDEX, 8'(8'h70 | s));
      repeat (2) @(posedge ref_clk);
      check(full_scale, s[1] ? 2 : s, "scale code");
    end
    rw(1, CONTROL_INDEX, 8'hFF);
    rw(0, CONTROL_INDEX, 8'h00);
    check(rd, 32'hF3, "control mask");
    repeat (2) @(posedge ref_clk);
    check({pin_out, pin_oe_n, pin_pullup_en, analog_connect, bias_enable},
          5'b01011, "pin takeover");
    rw(1, DATA_LOW_INDEX, 8'hFF);
    rw(0, DATA_LOW_INDEX, 8'h00);
    check(rd, 32'hC0, "low byte mask");
    repeat (4) @(posedge ref_clk);
    check(dac_code, 10'h000, "low write held");
    rw(0, STATUS_INDEX, 8'h00);
    check(rd, 32'h0001_0000, "low write pending");
    rw(1, DATA_HIGH_INDEX, 8'hA5);
    repeat (3) @(posedge ref_clk);
    check(dac_code, 10'h297, "on demand load");
    rw(0, STATUS_INDEX, 8'h00);
    check(rd, 32'h0000_0297, "latched word");
    rw(1, DATA_LOW_INDEX, 8'h00);
    rw(1, DATA_HIGH_INDEX, 8'h3C);
    repeat (3) @(posedge ref_clk);
    code = 10'h0F0;
    check(dac_code, code, "eight bit load");
    for (int t = 0; t < 4; t++) begin
      rw(1, CONTROL_INDEX, 8'(8'h80 | t << 4));
      rw(1, DATA_LOW_INDEX, 8'h40);
      rw(1, DATA_HIGH_INDEX, 8'(t + 1));
      i_event_source_model.pulse((t + 1) % 4);
      repeat (3) @(posedge ref_clk);
      check(dac_code, code, "timer held");
      rw(0, STATUS_INDEX, 8'h00);
      check(rd, {15'h0, 1'b1, 6'h0, code}, "timer pending");
      i_event_source_model.pulse(t);
      repeat (3) @(posedge ref_clk);
      code = {8'(t + 1), 2'b01};
      check(dac_code, code, "timer load");
    end
    for (int m = 4; m < 7; m++) begin
      rw(1, CONTROL_INDEX, 8'(8'h80 | m << 4));
      for (int e = 0; e < 2; e++) begin
        rw(1, DATA_HIGH_INDEX, 8'(m * 16 + e));
        i_event_source_model.level(e == 0);
        if (m == 6 || m == 4 + e) code = {8'(m * 16 + e), 2'b01};
        check(dac_code, code, "strobe edge");
      end
    end
    print_verdict;
  end
endmodule

/* File: sim/event_source_model.sv */
// Timer overflow and conversion strobe sources seen by the converter.
`timescale 1ns/10ps
module event_source_model (
  input  wire logic ref_clk,
  output logic [3:0] timer_overflow,
  output logic       strobe
);
  initial begin
    timer_overflow = 4'h0;
    strobe = 1'b0;
  end

  // One-cycle overflow pulse of timer n.
  task automatic pulse(input int n);
    timer_overflow[n] <= 1'b1;
    @(posedge ref_clk);
    timer_overflow <= 4'h0;
  endtask

  // The level is held long enough for the synchroniser to pass it.
  task automatic level(input logic v);
    strobe <= v;
    repeat (8) @(posedge ref_clk);
  endtask
endmodule
